// ===== hall_decoder_pkg.sv
/*
  Shared constants for the commutation decoder: register offsets,
  field positions, reset values, timer codes and filter codes.
  Assumes a 32-bit Wishbone slave with one register per aligned word.
*/
package hall_decoder_pkg;
  // Register byte offsets
  localparam logic [7:0] CTRL_OFS      = 8'h00;
  localparam logic [7:0] SOFT_POS_OFS  = 8'h04;
  localparam logic [7:0] FILT_CNT_OFS  = 8'h08;
  localparam logic [7:0] FILT_MODE_OFS = 8'h0C;
  localparam logic [7:0] SRC_EDGE_OFS  = 8'h10;
  localparam logic [7:0] STATUS_OFS    = 8'h14;
  localparam logic [7:0] TABLE_OFS     = 8'h40;
  localparam int         TABLE_ENTRIES = 12;
  localparam int         BACKWARD_BASE = 6;

  // Control register fields
  localparam int CTRL_ENABLE   = 0;
  localparam int CTRL_DIR      = 1;
  localparam int CTRL_BRAKE    = 2;
  localparam int CTRL_SRC_MODE = 3;
  localparam int CTRL_ANGLE    = 4;
  localparam int CTRL_DELAY    = 5;
  localparam int CTRL_TMR_LO   = 6;
  localparam int CTRL_TMR_HI   = 7;

  // Filter mode and source/edge fields
  localparam int FILT_EN       = 3;
  localparam int SRC_SEL       = 6;

  // Reset values
  localparam logic [7:0] CTRL_RESET      = 8'h10;
  localparam logic [7:0] SRC_EDGE_RESET  = 8'h00;
  localparam logic [4:0] FILT_CNT_RESET  = 5'h00;
  localparam logic [3:0] FILT_MODE_RESET = 4'h0;

  // Filter clock code with no sampling clock
  localparam logic [2:0] FILT_CLK_UNUSED = 3'h7;

  // Delay timer selection codes
  localparam logic [1:0] TMR_FIRST  = 2'h0;
  localparam logic [1:0] TMR_SECOND = 2'h1;
  localparam logic [1:0] TMR_TEN    = 2'h2;

  // Brake drive pattern: tops off, bottoms on
  localparam logic [5:0] BRAKE_PATTERN = 6'h15;
endpackage

// ===== position_noise_filter.sv
/*
  Three-channel noise filter for the rotor position inputs with its own
  sampling-rate divider. Assumes raw inputs are already synchronous.
*/
`timescale 1ns/1ps
module position_noise_filter (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       enable_i,
  input  wire logic [2:0] clock_select_i,
  input  wire logic [4:0] compare_count_i,
  input  wire logic [2:0] raw_i,
  output logic      [2:0] filtered_o
);
  logic [6:0] prescale_reg;
  logic [7:0] mask_wide;
  logic [6:0] mask;
  logic       tick;
  logic [5:0] limit;
  logic [2:0] held;

  // Sampling tick at the system clock over 2 to 128; the unused code stalls
  assign mask_wide = (8'h02 << clock_select_i) - 8'h01;
  assign mask      = mask_wide[6:0];
  assign tick      = (clock_select_i != hall_decoder_pkg::FILT_CLK_UNUSED)
                   && ((prescale_reg & mask) == mask);
  // A zero count still needs one sample, else the filter never settles
  assign limit     = (compare_count_i == 5'h00) ? 6'h01 : {1'b0, compare_count_i};

  always_ff @(posedge clk_i) begin
    if (rst_i) prescale_reg <= 7'h00;
    else       prescale_reg <= prescale_reg + 7'h01;
  end

  genvar i;
  generate
    for (i = 0; i < 3; i++) begin : g_chan
      logic [4:0] count_reg;
      // Change only after enough consecutive samples at the new level
      always_ff @(posedge clk_i) begin
        if (rst_i || !enable_i) begin
          count_reg <= 5'h00;
          held[i]   <= raw_i[i];
        end else if (tick) begin
          if (raw_i[i] == held[i]) begin
            count_reg <= 5'h00;
          end else if ({1'b0, count_reg} + 6'h01 >= limit) begin
            count_reg <= 5'h00;
            held[i]   <= raw_i[i];
          end else begin
            count_reg <= count_reg + 5'h01;
          end
        end
      end
    end
  endgenerate

  // Bypass path when disabled
  assign filtered_o = enable_i ? held : raw_i;
endmodule

// ===== position_delay.sv
/*
  Timer-driven delay of the decoder position word. A new position waits in
  the first buffer while the selected timer runs, then moves to the second
  on that timer's compare-A match. Assumes the timer stops and clears itself.
*/
`timescale 1ns/1ps
module position_delay (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       select_i,
  input  wire logic [1:0] timer_select_i,
  input  wire logic [2:0] pos_i,
  input  wire logic [2:0] timer_match_i,
  output logic      [2:0] pos_o,
  output logic      [2:0] dedicated_o,
  output logic      [2:0] hw_run_o
);
  logic [2:0] delay_buffer_first;
  logic [2:0] delay_buffer_second;
  logic       select_q;
  logic       running;
  logic       start;
  logic       match;
  logic       init;

  // Dedicated timer by code; code 3 picks none and the delay never fires
  assign dedicated_o[0] = select_i && (timer_select_i == hall_decoder_pkg::TMR_FIRST);
  assign dedicated_o[1] = select_i && (timer_select_i == hall_decoder_pkg::TMR_SECOND);
  assign dedicated_o[2] = select_i && (timer_select_i == hall_decoder_pkg::TMR_TEN);
  assign match    = |(timer_match_i & dedicated_o);
  assign init     = select_i && !select_q;
  assign start    = !init && !running && (pos_i != delay_buffer_second);
  assign hw_run_o = dedicated_o & {3{running}};

  // Buffers are flushed while off and seeded on the enabling edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      select_q            <= 1'b0;
      running             <= 1'b0;
      delay_buffer_first  <= 3'h0;
      delay_buffer_second <= 3'h0;
    end else begin
      select_q <= select_i;
      if (!select_i) begin
        running             <= 1'b0;
        delay_buffer_first  <= 3'h0;
        delay_buffer_second <= 3'h0;
      end else if (init) begin
        running             <= 1'b0;
        delay_buffer_first  <= pos_i;
        delay_buffer_second <= pos_i;
      end else if (running && match) begin
        running             <= 1'b0;
        delay_buffer_second <= delay_buffer_first;
      end else if (start) begin
        running             <= 1'b1;
        delay_buffer_first  <= pos_i;
      end
    end
  end

  assign pos_o = select_i ? delay_buffer_second : pos_i;
endmodule

// ===== hall_commutation_decoder.sv
/*
  Commutation decoder top: Wishbone register file, input source selection,
  noise filter, optional timer delay, edge events and the decode tables.
  Assumes pins and comparator outputs are asynchronous, timer signals are
  on clk_i, and a gate stage downstream consumes the six pattern bits.
*/
`timescale 1ns/1ps
// Notes on behaviour
// - Filter enable low bypasses the filter; high routes inputs through it.
// - Filter sampling clock comes from the 3-bit clock select field.
// - 5-bit count field sets how many comparisons the filter makes.
// - Delay is off while its select is low; a rising select initialises it.
// - Both 3-bit delay buffers stay cleared while the delay select is low.
// - With delay select low all three timers run normally.
// - With delay select high hardware drives the chosen timer's run bit.
// - Enabled, no brake: direction 0 uses forward, 1 backward tables.
// - Forward uses entries 0 to 5, bits 5..0 A top to C bottom.
// - Backward uses entries 6 to 11 with the same bit order.
// - 60-degree states 100,110,111,011,001,000 map to entries 0..5.
// - 120-degree states 100,110,010,011,001,101 map to entries 0..5.
// - Brake forces tops 0 and bottoms 1 regardless of everything else.
// - Source bit 6 picks sensor pins at 0, comparators 1 to 3 at 1.
// - Each filtered bit has 2-bit edge select: off, rise, fall, both.
// - Decode mode 1 uses filtered signals, 0 uses software position bits.
// - Angle bit 0 is 60-degree, 1 is 120-degree; resets to 1.
// - Clock codes 000..110 divide by 2..128; code 111 is unused.
// - Timer codes 00, 01, 10 pick the three timers; 11 unused.
module hall_commutation_decoder (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic        rotor_pos_a_in_i,
  input  wire logic        rotor_pos_b_in_i,
  input  wire logic        rotor_pos_c_in_i,
  input  wire logic [2:0]  comparator_out_i,
  input  wire logic [2:0]  timer_match_i,
  input  wire logic [2:0]  sw_run_i,
  output logic      [2:0]  counter_run_bit_o,
  output logic      [2:0]  timer_dedicated_o,
  output logic      [2:0]  edge_event_o,
  output logic             gate_a_top_o,
  output logic             gate_a_bottom_o,
  output logic             gate_b_top_o,
  output logic             gate_b_bottom_o,
  output logic             gate_c_top_o,
  output logic             gate_c_bottom_o
);
  localparam int TABLE_COUNT = hall_decoder_pkg::TABLE_ENTRIES;

  logic [7:0]  decoder_control_reg;
  logic [2:0]  software_position_reg;
  logic [4:0]  filter_count_reg;
  logic [3:0]  filter_mode_reg;
  logic [6:0]  sensor_source_edge_ctrl;
  logic [5:0]  commutation_table_entry [TABLE_COUNT];
  logic [5:0]  pattern_reg;
  logic [5:0]  pattern_next;
  logic [2:0]  filtered_prev_reg;
  logic [2:0]  edge_reg;
  logic        ack_reg;
  logic [31:0] rdata_reg;
  logic [5:0]  sync1_reg;
  logic [5:0]  sync2_reg;

  logic        access;
  logic        wr;
  logic        tbl_hit;
  logic [7:0]  tbl_off;
  logic [3:0]  tbl_idx;
  logic [2:0]  filter_in;
  logic [2:0]  filtered_pos;
  logic [2:0]  decode_in;
  logic [2:0]  delayed_pos;
  logic [2:0]  hw_run;
  logic [2:0]  rise;
  logic [2:0]  fall;
  logic [2:0]  edge_hit;
  logic        valid_60;
  logic        valid_120;
  logic        valid_pos;
  logic [2:0]  step_60;
  logic [2:0]  step_120;
  logic [2:0]  step;
  logic [3:0]  entry_idx;
  logic [31:0] rdata_next;

  logic        decoder_enable;
  logic        direction_select;
  logic        brake_enable;
  logic        decode_source_mode;
  logic        angle_config_select;
  logic        delay_circuit_select;
  logic [1:0]  delay_timer_select;

  // Control field decode
  assign decoder_enable       = decoder_control_reg[hall_decoder_pkg::CTRL_ENABLE];
  assign direction_select     = decoder_control_reg[hall_decoder_pkg::CTRL_DIR];
  assign brake_enable         = decoder_control_reg[hall_decoder_pkg::CTRL_BRAKE];
  assign decode_source_mode   = decoder_control_reg[hall_decoder_pkg::CTRL_SRC_MODE];
  assign angle_config_select  = decoder_control_reg[hall_decoder_pkg::CTRL_ANGLE];
  assign delay_circuit_select = decoder_control_reg[hall_decoder_pkg::CTRL_DELAY];
  assign delay_timer_select   = decoder_control_reg[hall_decoder_pkg::CTRL_TMR_HI:hall_decoder_pkg::CTRL_TMR_LO];

  // Bus decode; the slave answers one cycle after the request
  assign access  = cyc_i && stb_i && !ack_reg;
  assign wr      = access && we_i && sel_i[0];
  assign tbl_off = adr_i - hall_decoder_pkg::TABLE_OFS;
  assign tbl_idx = tbl_off[5:2];
  assign tbl_hit = (adr_i >= hall_decoder_pkg::TABLE_OFS) && (tbl_off[1:0] == 2'h0)
                 && (tbl_off[7:6] == 2'h0) && (tbl_idx < 4'(TABLE_COUNT));

  // Pins and comparators are asynchronous, so both pass two flops
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= 6'h00;
      sync2_reg <= 6'h00;
    end else begin
      sync1_reg <= {comparator_out_i, rotor_pos_c_in_i, rotor_pos_b_in_i, rotor_pos_a_in_i};
      sync2_reg <= sync1_reg;
    end
  end

  // Filter source: sensor pins or comparators 1 to 3
  assign filter_in = sensor_source_edge_ctrl[hall_decoder_pkg::SRC_SEL]
                   ? sync2_reg[5:3] : sync2_reg[2:0];

  position_noise_filter u_filter (
    .clk_i           (clk_i),
    .rst_i           (rst_i),
    .enable_i        (filter_mode_reg[hall_decoder_pkg::FILT_EN]),
    .clock_select_i  (filter_mode_reg[2:0]),
    .compare_count_i (filter_count_reg),
    .raw_i           (filter_in),
    .filtered_o      (filtered_pos)
  );

  // Decoder input: filtered signals or software bits
  assign decode_in = decode_source_mode ? filtered_pos : software_position_reg;

  position_delay u_delay (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .select_i       (delay_circuit_select),
    .timer_select_i (delay_timer_select),
    .pos_i          (decode_in),
    .timer_match_i  (timer_match_i),
    .pos_o          (delayed_pos),
    .dedicated_o    (timer_dedicated_o),
    .hw_run_o       (hw_run)
  );

  // Run bits: software owns them unless the timer is dedicated to the delay
  assign counter_run_bit_o = (sw_run_i & ~timer_dedicated_o) | hw_run;

  // Edge events on each filtered position bit
  assign rise = filtered_pos & ~filtered_prev_reg;
  assign fall = ~filtered_pos & filtered_prev_reg;
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_edge
      assign edge_hit[g] = (sensor_source_edge_ctrl[2*g] && rise[g])
                         || (sensor_source_edge_ctrl[2*g+1] && fall[g]);
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      filtered_prev_reg <= 3'h0;
      edge_reg          <= 3'h0;
    end else begin
      filtered_prev_reg <= filtered_pos;
      edge_reg          <= edge_hit;
    end
  end
  assign edge_event_o = edge_reg;

  // Step index for 60 degrees (A is bit 2 of the state)
  always_comb begin
    valid_60 = 1'b1;
    case ({delayed_pos[0], delayed_pos[1], delayed_pos[2]})
      3'h4:    step_60 = 3'h0;
      3'h6:    step_60 = 3'h1;
      3'h7:    step_60 = 3'h2;
      3'h3:    step_60 = 3'h3;
      3'h1:    step_60 = 3'h4;
      3'h0:    step_60 = 3'h5;
      default: begin
        step_60  = 3'h0;
        valid_60 = 1'b0;
      end
    endcase
  end

  // Step index for 120 degrees
  always_comb begin
    valid_120 = 1'b1;
    case ({delayed_pos[0], delayed_pos[1], delayed_pos[2]})
      3'h4:    step_120 = 3'h0;
      3'h6:    step_120 = 3'h1;
      3'h2:    step_120 = 3'h2;
      3'h3:    step_120 = 3'h3;
      3'h1:    step_120 = 3'h4;
      3'h5:    step_120 = 3'h5;
      default: begin
        step_120  = 3'h0;
        valid_120 = 1'b0;
      end
    endcase
  end

  assign valid_pos = angle_config_select ? valid_120 : valid_60;
  assign step      = angle_config_select ? step_120 : step_60;
  // Backward table sits six entries above the forward one
  assign entry_idx = direction_select ? ({1'b0, step} + 4'(hall_decoder_pkg::BACKWARD_BASE))
                                      : {1'b0, step};

  // Output priority: brake, then disabled, then invalid state, then table
  always_comb begin
    if (brake_enable)        pattern_next = hall_decoder_pkg::BRAKE_PATTERN;
    else if (!decoder_enable) pattern_next = 6'h00;
    else if (!valid_pos)     pattern_next = 6'h00;
    else                     pattern_next = commutation_table_entry[entry_idx];
  end

  // Read mux; unmapped words read zero
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (tbl_hit) rdata_next = {26'h0, commutation_table_entry[tbl_idx]};
    else begin
      case (adr_i)
        hall_decoder_pkg::CTRL_OFS:      rdata_next = {24'h0, decoder_control_reg};
        hall_decoder_pkg::SOFT_POS_OFS:  rdata_next = {29'h0, software_position_reg};
        hall_decoder_pkg::FILT_CNT_OFS:  rdata_next = {27'h0, filter_count_reg};
        hall_decoder_pkg::FILT_MODE_OFS: rdata_next = {28'h0, filter_mode_reg};
        hall_decoder_pkg::SRC_EDGE_OFS:  rdata_next = {25'h0, sensor_source_edge_ctrl};
        hall_decoder_pkg::STATUS_OFS:    rdata_next = {18'h0, pattern_reg, 2'h0, delayed_pos, filtered_pos};
        default:                         rdata_next = 32'h0000_0000;
      endcase
    end
  end

  // Register writes take only byte lane 0
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      decoder_control_reg     <= hall_decoder_pkg::CTRL_RESET;
      software_position_reg   <= 3'h0;
      filter_count_reg        <= hall_decoder_pkg::FILT_CNT_RESET;
      filter_mode_reg         <= hall_decoder_pkg::FILT_MODE_RESET;
      sensor_source_edge_ctrl <= hall_decoder_pkg::SRC_EDGE_RESET[6:0];
    end else if (wr) begin
      case (adr_i)
        hall_decoder_pkg::CTRL_OFS:      decoder_control_reg     <= dat_i[7:0];
        hall_decoder_pkg::SOFT_POS_OFS:  software_position_reg   <= dat_i[2:0];
        hall_decoder_pkg::FILT_CNT_OFS:  filter_count_reg        <= dat_i[4:0];
        hall_decoder_pkg::FILT_MODE_OFS: filter_mode_reg         <= dat_i[3:0];
        hall_decoder_pkg::SRC_EDGE_OFS:  sensor_source_edge_ctrl <= dat_i[6:0];
        default:                         ;
      endcase
    end
  end

  // Table entries, one generate slice each
  generate
    for (g = 0; g < TABLE_COUNT; g++) begin : g_table
      always_ff @(posedge clk_i) begin
        if (rst_i)                              commutation_table_entry[g] <= 6'h00;
        else if (wr && tbl_hit && tbl_idx == 4'(g)) commutation_table_entry[g] <= dat_i[5:0];
      end
    end
  endgenerate

  // Bus answer and registered pattern
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg     <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      pattern_reg <= 6'h00;
    end else begin
      ack_reg     <= access;
      rdata_reg   <= access ? rdata_next : 32'h0000_0000;
      pattern_reg <= pattern_next;
    end
  end

  assign ack_o           = ack_reg;
  assign dat_o           = rdata_reg;
  assign gate_a_top_o    = pattern_reg[5];
  assign gate_a_bottom_o = pattern_reg[4];
  assign gate_b_top_o    = pattern_reg[3];
  assign gate_b_bottom_o = pattern_reg[2];
  assign gate_c_top_o    = pattern_reg[1];
  assign gate_c_bottom_o = pattern_reg[0];
endmodule

// ===== hall_partner.sv
/*
  Far-side model: three Hall sensors, comparators 1 to 3 and the three
  candidate delay timers. Assumes states are coded (A,B,C) with A on top.
*/
`timescale 1ns/1ps
module hall_partner #(
  parameter int DELAY = 20
) (
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic [2:0] pin_state_i,
  input  wire logic [2:0] cmp_state_i,
  input  wire logic [2:0] run_i,
  output logic            pos_a_o,
  output logic            pos_b_o,
  output logic            pos_c_o,
  output logic      [2:0] cmp_o,
  output logic      [2:0] match_o
);
  int cnt [3];
  // Sensors hold static levels; comparator bus carries A on bit 0
  assign {pos_a_o, pos_b_o, pos_c_o} = pin_state_i;
  assign cmp_o = {cmp_state_i[0], cmp_state_i[1], cmp_state_i[2]};
  // Compare match mode, cleared on compare A; DELAY stays under one Hall step
  always_ff @(posedge clk_i) begin
    for (int i = 0; i < 3; i++) begin
      match_o[i] <= 1'b0;
      if (rst_i || !run_i[i]) begin
        cnt[i] <= 0;
      end else if (cnt[i] == DELAY - 1) begin
        cnt[i] <= 0;
        match_o[i] <= 1'b1;
      end else begin
        cnt[i] <= cnt[i] + 1;
      end
    end
  end
endmodule

// ===== hall_commutation_decoder_monitor.sv
/*
  Port-level checker for the commutation decoder. Shadows the control and
  edge registers from bus writes; assumes bus writes land on the taken edge.
*/
`timescale 1ns/1ps
module hall_commutation_decoder_monitor (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [2:0]  sw_run_i,
  input wire logic [2:0]  counter_run_bit_o,
  input wire logic [2:0]  timer_dedicated_o,
  input wire logic [2:0]  edge_event_o,
  input wire logic        gate_a_top_o,
  input wire logic        gate_a_bottom_o,
  input wire logic        gate_b_top_o,
  input wire logic        gate_b_bottom_o,
  input wire logic        gate_c_top_o,
  input wire logic        gate_c_bottom_o
);
  logic [7:0] ctrl_q;
  logic [7:0] src_q;
  // Decoded shadow state
  wire       wr_take = cyc_i && stb_i && we_i && !ack_o && sel_i[0];
  wire [5:0] gates   = {gate_a_top_o, gate_a_bottom_o, gate_b_top_o, gate_b_bottom_o, gate_c_top_o, gate_c_bottom_o};
  wire       brk     = ctrl_q[hall_decoder_pkg::CTRL_BRAKE];
  wire       idle    = !ctrl_q[hall_decoder_pkg::CTRL_ENABLE] && !brk;
  wire [2:0] own     = {2'h0, ctrl_q[hall_decoder_pkg::CTRL_DELAY]} << ctrl_q[7:6];
  wire [2:0] edge_on = {|src_q[5:4], |src_q[3:2], |src_q[1:0]};
  // Shadow registers follow taken writes only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= hall_decoder_pkg::CTRL_RESET;
      src_q  <= hall_decoder_pkg::SRC_EDGE_RESET;
    end else if (wr_take && adr_i == hall_decoder_pkg::CTRL_OFS) begin
      ctrl_q <= dat_i[7:0];
    end else if (wr_take && adr_i == hall_decoder_pkg::SRC_EDGE_OFS) begin
      src_q <= dat_i[7:0];
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Pattern register lags control by one edge, hence two-sample holds
  sequence s_brake_held;
    brk ##1 brk;
  endsequence
  sequence s_free_held;
    idle ##1 idle;
  endsequence
  a_brake_pattern: assert property (s_brake_held |-> gates == hall_decoder_pkg::BRAKE_PATTERN)
    else $error("brake pattern wrong");
  a_disabled_free: assert property (s_free_held |-> gates == 6'h00)
    else $error("disabled decoder drives gates");
  a_timer_owner: assert property (timer_dedicated_o == own)
    else $error("wrong timer dedicated");
  a_run_normal: assert property ((counter_run_bit_o & ~own) == (sw_run_i & ~own))
    else $error("free timer run bit altered");
  a_edge_enabled: assert property ((edge_event_o & $past(edge_on)) == edge_event_o)
    else $error("edge event with select off");
  a_ack_answer: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("bus request not acknowledged");
  a_ack_single: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
  a_idle_data: assert property (!ack_o |-> dat_o == 32'h0)
    else $error("read data outside ack");
endmodule
bind hall_commutation_decoder hall_commutation_decoder_monitor mon (.*);

// ===== tb_hall_commutation_decoder.sv
/*
  Self-checking bench for the commutation decoder with the far-side model.
  Assumes the bus slave acks one cycle after taking a request.
*/
`timescale 1ns/1ps
module tb_hall_commutation_decoder;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        cyc = 1'b0;
  logic        stb = 1'b0;
  logic        we  = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'hF;
  logic [31:0] wdat = 32'h0;
  logic [2:0]  ps = 3'h4;
  logic [2:0]  cs = 3'h3;
  logic [2:0]  sw_run = 3'h5;
  wire  [31:0] rdat;
  wire         ack, pa, pb, pc;
  wire  [2:0]  cmp, match, run, ded, evt;
  wire  [5:0]  g;
  int          err_total = 0;
  int          checked = 0;
  int          ecount = 0;
  logic [2:0]  states [2][8] = '{'{3'h4, 3'h6, 3'h7, 3'h3, 3'h1, 3'h0, 3'h5, 3'h2},
                                 '{3'h4, 3'h6, 3'h2, 3'h3, 3'h1, 3'h5, 3'h7, 3'h0}};
  hall_commutation_decoder dut (.clk_i(clk), .rst_i(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
    .sel_i(sel), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .rotor_pos_a_in_i(pa), .rotor_pos_b_in_i(pb),
    .rotor_pos_c_in_i(pc), .comparator_out_i(cmp), .timer_match_i(match), .sw_run_i(sw_run),
    .counter_run_bit_o(run), .timer_dedicated_o(ded), .edge_event_o(evt), .gate_a_top_o(g[5]),
    .gate_a_bottom_o(g[4]), .gate_b_top_o(g[3]), .gate_b_bottom_o(g[2]), .gate_c_top_o(g[1]), .gate_c_bottom_o(g[0]));
  hall_partner #(.DELAY(20)) far (.clk_i(clk), .rst_i(rst), .pin_state_i(ps), .cmp_state_i(cs), .run_i(run),
    .pos_a_o(pa), .pos_b_o(pb), .pos_c_o(pc), .cmp_o(cmp), .match_o(match));
  // Clock and event counter on filtered A edges
  always #5 clk = ~clk;
  always @(posedge clk) if (evt[0] === 1'b1) ecount++;
  // Distinct nonzero pattern per table entry
  function automatic logic [5:0] tbl(input int n);
    return 6'(n * 7 + 3);
  endfunction
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic chkg(input logic [5:0] e);
    chk("gates", {26'h0, g}, {26'h0, e});
  endtask
  // Classic cycle: hold until ack is sampled, then drop for a cycle
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk); while (ack !== 1'b1);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic step(input logic [2:0] s, input int w, input logic [5:0] e);
    ps <= s;
    repeat (w) @(posedge clk);
    chkg(e);
  endtask
  task automatic t_regs();
    logic [31:0] q;
    wr(8'h3C, 32'hFF);
    wb(1'b0, 8'h3C, 32'h0, q);
    chk("unmapped", q, 32'h0);
    wb(1'b0, hall_decoder_pkg::CTRL_OFS, 32'h0, q);
    chk("ctrl reset", q, 32'h10);
    wb(1'b0, hall_decoder_pkg::SRC_EDGE_OFS, 32'h0, q);
    chk("source reset", q, 32'h0);
  endtask
  task automatic t_decode();
    logic [2:0] s;
    for (int i = 0; i < 12; i++) wr(8'(hall_decoder_pkg::TABLE_OFS + 4 * i), {26'h0, tbl(i)});
    for (int a = 0; a < 2; a++) begin
      for (int d = 0; d < 2; d++) begin
        wr(hall_decoder_pkg::CTRL_OFS, 32'(1 + 2 * d + 16 * a));
        for (int i = 0; i < 8; i++) begin
          s = states[a][i];
          wr(hall_decoder_pkg::SOFT_POS_OFS, {29'h0, s[0], s[1], s[2]});
          repeat (2) @(posedge clk);
          chkg(i < 6 ? tbl(6 * d + i) : 6'h00);
        end
      end
    end
    wr(hall_decoder_pkg::SOFT_POS_OFS, 32'h1);
    wr(hall_decoder_pkg::CTRL_OFS, 32'h05);
    step(3'h4, 2, hall_decoder_pkg::BRAKE_PATTERN);
    wr(hall_decoder_pkg::CTRL_OFS, 32'h06);
    step(3'h4, 2, hall_decoder_pkg::BRAKE_PATTERN);
    wr(hall_decoder_pkg::CTRL_OFS, 32'h00);
    step(3'h4, 2, 6'h00);
  endtask
  task automatic t_pins();
    wr(hall_decoder_pkg::CTRL_OFS, 32'h09);
    step(3'h6, 4, tbl(1));
    wr(hall_decoder_pkg::SRC_EDGE_OFS, 32'h40);
    step(3'h6, 4, tbl(3));
    wr(hall_decoder_pkg::SRC_EDGE_OFS, 32'h00);
    wr(hall_decoder_pkg::FILT_CNT_OFS, 32'h3);
    wr(hall_decoder_pkg::FILT_MODE_OFS, 32'h08);
    step(3'h6, 40, tbl(1));
    step(3'h7, 5, tbl(1));
    step(3'h7, 30, tbl(2));
    wr(hall_decoder_pkg::FILT_MODE_OFS, 32'h0E);
    step(3'h3, 200, tbl(2));
    step(3'h3, 400, tbl(3));
    wr(hall_decoder_pkg::FILT_MODE_OFS, 32'h0F);
    step(3'h1, 300, tbl(3));
    wr(hall_decoder_pkg::FILT_MODE_OFS, 32'h00);
    step(3'h1, 4, tbl(4));
  endtask
  task automatic t_edges();
    for (int c = 0; c < 4; c++) begin
      wr(hall_decoder_pkg::SRC_EDGE_OFS, 32'(c));
      step(3'h0, 10, tbl(5));
      ecount = 0;
      step(3'h4, 10, tbl(0));
      chk("rise events", 32'(ecount), 32'(c & 1));
      ecount = 0;
      step(3'h0, 10, tbl(5));
      chk("fall events", 32'(ecount), 32'(c >> 1));
    end
  endtask
  // Setup order: source mode, timer, delay select, then enable
  task automatic t_delay();
    ps <= 3'h4;
    wr(hall_decoder_pkg::CTRL_OFS, 32'h08);
    wr(hall_decoder_pkg::CTRL_OFS, 32'h48);
    wr(hall_decoder_pkg::CTRL_OFS, 32'h68);
    wr(hall_decoder_pkg::CTRL_OFS, 32'h69);
    chk("owner", {29'h0, ded}, 32'h2);
    step(3'h4, 4, tbl(0));
    step(3'h6, 8, tbl(0));
    chk("hw run", {31'h0, run[1]}, 32'h1);
    step(3'h6, 30, tbl(1));
    for (int c = 0; c < 4; c++) begin
      wr(hall_decoder_pkg::CTRL_OFS, 32'(c * 64 + 41));
      chk("owner", {29'h0, ded}, c == 3 ? 32'h0 : 32'(1 << c));
    end
    wr(hall_decoder_pkg::CTRL_OFS, 32'h09);
    step(3'h3, 4, tbl(3));
  endtask
  task automatic end_of_test();
    if (err_total == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    repeat (12) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_regs();
    t_decode();
    t_pins();
    t_edges();
    t_delay();
    end_of_test();
  end
  // Watchdog well beyond the roughly 1500 cycles the run needs
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    end_of_test();
  end
endmodule
